// file: parameter_access_guard.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "param_guard_regs.svh"
// Notes on behaviour
// RULE1: Direction lock codes: 0 both, 1 no reverse, 2 no forward; reset 0.
// RULE2: Direction lock filters panel keys, start inputs and network commands alike.
// RULE3: Direction lock writable only while display selector is 0.
// RULE4: Display selector resets to 9999 simple set; 0 shows extended too.
// RULE5: Display selector writable while running, any mode, any write-protect.
// RULE6: Serial reads with source selection not 2 ignore the display selector.
// RULE7: Jog speed, jog ramp, contrast count as simple when unit fitted.
// RULE8: Lock level accepts 1-6, 101-106, 9999 no lock; reset 9999.
// RULE9: Password 1000-9998 registers and enforces lock level until unlocked.
// RULE10: Locked access gated per path by level table.
// RULE11: Lock-allowed access still refused by display selector or write-protect.
// RULE12: Local limits hit selected local source; network limits hit network mode.
// RULE13: Levels 1-6 report zero; 101-106 count errors 0-5, lock out at fifth.
// RULE14: After five errors correct password fails; only full clear unlocks.
// RULE15: Password registration refused while lock level is 9999.
// RULE16: Registered password reads return only error count.
// RULE17: Password writable via display 0 with no lock, always once lock set.
// RULE18: Writes of 0 or 9999 to password accepted but ignored.
// RULE19: Correct password unlocks; wrong one errors and counts at counting levels.
// RULE20: Internal parameter updates bypass the password lock.
// RULE21: Contrast stays accessible from fitted parameter unit while locked.
// RULE22: Lock refusal raises a dedicated lock-error indication.
// RULE23: Full clear restores no-lock level, password and zero error count.
module parameter_access_guard (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire param_guard_pkg::dir_cmd_t panel_dir,
  input wire param_guard_pkg::dir_cmd_t unit_dir,
  input wire logic forward_start_input,
  input wire logic reverse_start_input,
  input wire param_guard_pkg::dir_cmd_t net_dir,
  output param_guard_pkg::dir_cmd_t run_dir,
  input wire logic running,
  input wire logic network_mode,
  input wire logic unit_fitted,
  input wire logic local_is_unit,
  input wire logic local_operator_path_unit,
  input wire param_guard_pkg::access_req_t access_req,
  input wire logic internal_write,
  output param_guard_pkg::access_ans_t access_ans,
  output logic lock_error_display
);
  // ----------------------------------------
  // Settings
  // ----------------------------------------
  logic [13:0] direction_lock_setting;
  logic [13:0] display_level_selector;
  logic [13:0] lock_level_setting;
  logic [13:0] password_value;
  logic [13:0] write_protect_selection;
  logic [13:0] local_command_source_selection;
  logic registered;
  logic locked;
  logic [2:0] err_count;
  logic [13:0] wdat;
  logic extended;
  logic lock_set;
  logic counting;
  logic lockout;
  logic [13:0] lvl;
  logic full_clear;
  logic pw_wr;
  logic pw_write_ok;

  assign wdat = reg_wdata[13:0];
  assign extended = display_level_selector == `DISP_EXTENDED;
  assign lock_set = lock_level_setting != `NO_LOCK;
  // The no-lock value also lies above the counting base, so it must be excluded
  assign counting = lock_set && lock_level_setting > `LVL_CNT_BASE;
  assign lvl = counting ? lock_level_setting - `LVL_CNT_BASE : lock_level_setting;
  assign lockout = counting && (err_count == `LOCK_ERR_LIMIT); // RULE14
  // Clear is refused while the motor runs
  assign full_clear = reg_wr && reg_addr == `OFS_CLEAR && reg_wdata[0] && !running;
  assign pw_wr = reg_wr && reg_addr == `OFS_PASSWORD;
  assign pw_write_ok = pw_wr && (lock_set || extended); // RULE17

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      direction_lock_setting <= `DIR_BOTH; // RULE1
    end else if (full_clear) begin
      direction_lock_setting <= `DIR_BOTH;
    end else if (reg_wr && reg_addr == `OFS_DIR_LOCK && extended && !locked &&
                 wdat <= `DIR_NO_FWD) begin
      direction_lock_setting <= wdat; // RULE3
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      display_level_selector <= `DISP_SIMPLE; // RULE4
    end else if (full_clear) begin
      display_level_selector <= `DISP_SIMPLE;
    end else if (reg_wr && reg_addr == `OFS_DISP_LEVEL && !locked &&
                 (wdat == `DISP_SIMPLE || wdat == `DISP_EXTENDED)) begin
      display_level_selector <= wdat; // RULE5
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      write_protect_selection <= `WP_RESET;
      local_command_source_selection <= `SRC_SEL_RESET;
    end else if (full_clear) begin
      write_protect_selection <= `WP_RESET;
      local_command_source_selection <= `SRC_SEL_RESET;
    end else if (reg_wr && !locked) begin
      if (reg_addr == `OFS_WRITE_PROT && extended) begin
        write_protect_selection <= wdat;
      end
      if (reg_addr == `OFS_SRC_SEL && extended) begin
        local_command_source_selection <= wdat;
      end
    end
  end

  // ----------------------------------------
  // Lock level, password and error counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lock_level_setting <= `NO_LOCK; // RULE8
    end else if (full_clear) begin
      lock_level_setting <= `NO_LOCK; // RULE23
    end else if (reg_wr && reg_addr == `OFS_LOCK_LEVEL && extended && !registered &&
                 (wdat == `NO_LOCK || (wdat >= 14'h0001 && wdat <= 14'h0006) ||
                  (wdat >= 14'h0065 && wdat <= 14'h006A))) begin
      lock_level_setting <= wdat; // RULE8
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      password_value <= `NO_LOCK;
      registered <= 1'b0;
      locked <= 1'b0;
    end else if (full_clear) begin
      password_value <= `NO_LOCK; // RULE23
      registered <= 1'b0;
      locked <= 1'b0;
    end else if (pw_write_ok && wdat >= `PW_MIN && wdat <= `PW_MAX) begin // RULE18
      if (!registered && lock_set) begin // RULE15
        password_value <= wdat; // RULE9
        registered <= 1'b1;
        locked <= 1'b1;
      end else if (registered && locked && !lockout && wdat == password_value) begin
        locked <= 1'b0; // RULE19
        registered <= 1'b0;
        password_value <= `NO_LOCK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_count <= 3'h0;
    end else if (full_clear) begin
      err_count <= 3'h0; // RULE23
    // Errors survive an unlock; only a full clear starts the count again
    end else if (pw_write_ok && locked && counting && !lockout &&
                 wdat >= `PW_MIN && wdat <= `PW_MAX && wdat != password_value) begin
      err_count <= err_count + 3'h1; // RULE13
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `OFS_DIR_LOCK: reg_rdata <= {2'h0, direction_lock_setting};
        `OFS_DISP_LEVEL: reg_rdata <= {2'h0, display_level_selector};
        `OFS_LOCK_LEVEL: reg_rdata <= {2'h0, lock_level_setting};
        `OFS_PASSWORD: reg_rdata <= registered ?
                                    {13'h0000, counting ? err_count : 3'h0} : // RULE16
                                    {2'h0, password_value};
        `OFS_WRITE_PROT: reg_rdata <= {2'h0, write_protect_selection};
        `OFS_SRC_SEL: reg_rdata <= {2'h0, local_command_source_selection};
        `OFS_STATUS: reg_rdata <= {13'h0000, lockout, registered, locked};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Direction filter
  // ----------------------------------------
  logic any_fwd;
  logic any_rev;
  assign any_fwd = panel_dir.fwd | unit_dir.fwd | forward_start_input | net_dir.fwd; // RULE2
  assign any_rev = panel_dir.rev | unit_dir.rev | reverse_start_input | net_dir.rev; // RULE2

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_dir <= '0;
    end else begin
      run_dir.fwd <= any_fwd && direction_lock_setting != `DIR_NO_FWD; // RULE1
      run_dir.rev <= any_rev && direction_lock_setting != `DIR_NO_REV; // RULE1
    end
  end

  // ----------------------------------------
  // Access gate
  // ----------------------------------------
  logic lvl_blocks;
  logic disp_hides;
  logic wp_blocks;
  logic simple_param;
  logic selected_local;
  logic is_contrast;

  always_comb begin
    lvl_blocks = 1'b0;
    if (locked) begin // RULE10
      unique case (lvl)
        14'h0001: lvl_blocks = access_req.write;
        14'h0002: lvl_blocks = access_req.write && !access_req.network;
        14'h0003: lvl_blocks = access_req.write && access_req.network;
        14'h0004: lvl_blocks = 1'b1;
        14'h0005: lvl_blocks = !access_req.network;
        14'h0006: lvl_blocks = access_req.network;
        default: lvl_blocks = 1'b0;
      endcase
    end
  end

  // Only the selected local source and network-mode serial access are restricted
  assign selected_local = !access_req.network && (local_operator_path_unit == local_is_unit);
  assign is_contrast = access_req.param == `PARAM_CONTRAST;
  assign simple_param = access_req.simple || (unit_fitted && (is_contrast || // RULE7
                        access_req.param == `PARAM_JOG_SPEED ||
                        access_req.param == `PARAM_JOG_RAMP));
  assign disp_hides = !extended && !simple_param &&
                      !(access_req.network && !access_req.write &&
                        local_command_source_selection != `SRC_SEL_PANEL_ONLY); // RULE6
  assign wp_blocks = access_req.write && access_req.param != `PARAM_DISP_LEVEL && // RULE5
                     access_req.param != `PARAM_WRITE_PROT &&
                     access_req.param != `PARAM_LOCK_LEVEL &&
                     access_req.param != `PARAM_PASSWORD &&
                     (write_protect_selection == `WP_NONE ||
                      (write_protect_selection == `WP_RESET && running)); // RULE11

  logic path_lock;
  assign path_lock = lvl_blocks && (selected_local || (access_req.network && network_mode)) &&
                     !(is_contrast && unit_fitted && !access_req.network); // RULE12 RULE21

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      access_ans <= '0;
      lock_error_display <= 1'b0;
    end else begin
      access_ans.done <= access_req.valid;
      access_ans.granted <= access_req.valid &&
                            (internal_write || (!path_lock && !disp_hides && !wp_blocks)); // RULE20 RULE11
      access_ans.lock_error <= access_req.valid && !internal_write && path_lock; // RULE22
      lock_error_display <= access_req.valid ? (!internal_write && path_lock) :
                            lock_error_display; // RULE22
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_DIR_NO_REV: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
    direction_lock_setting == `DIR_NO_REV |=> !run_dir.rev)
    else $error("reverse passed while blocked");
  AST_DIR_NO_FWD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
    (direction_lock_setting == `DIR_NO_FWD) |=> !run_dir.fwd)
    else $error("forward passed while blocked");
  AST_ERR_MAX: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
    err_count <= `LOCK_ERR_LIMIT)
    else $error("error count above five");
  AST_LOCKOUT_HOLD: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
    lockout && !full_clear |=> locked)
    else $error("lockout released without clear");
  AST_NO_REG_NOLOCK: assert property (@(posedge core_clk) disable iff (!nrst) // RULE15
    !lock_set && !registered |=> !registered)
    else $error("password registered without lock level");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst) // RULE23
    full_clear |=> lock_level_setting == `NO_LOCK && err_count == 3'h0 && !locked)
    else $error("clear did not restore lock state");
  AST_LOCK_ERR: assert property (@(posedge core_clk) disable iff (!nrst) // RULE22
    access_req.valid && path_lock && !internal_write |=> access_ans.lock_error && !access_ans.granted)
    else $error("lock refusal not flagged");
  AST_INTERNAL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE20
    access_req.valid && internal_write |=> access_ans.granted)
    else $error("internal write refused");
  AST_PW_READ: assert property (@(posedge core_clk) disable iff (!nrst) // RULE16
    reg_rd && reg_addr == `OFS_PASSWORD && registered |=> reg_rdata <= 16'h0005)
    else $error("password value leaked");
  AST_DISP_HIDES: assert property (@(posedge core_clk) disable iff (!nrst) // RULE4
    access_req.valid && !internal_write && disp_hides |=> !access_ans.granted)
    else $error("hidden parameter granted");
  AST_SERIAL_READ: assert property (@(posedge core_clk) disable iff (!nrst) // RULE6
    access_req.valid && access_req.network && !access_req.write && !path_lock &&
    local_command_source_selection != `SRC_SEL_PANEL_ONLY |=> access_ans.granted)
    else $error("serial read refused");
  AST_WP_BLOCKS: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
    access_req.valid && !internal_write && wp_blocks |=> !access_ans.granted)
    else $error("write-protected parameter granted");
  AST_DISP_FREE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
    access_req.valid && access_req.param == `PARAM_DISP_LEVEL && !path_lock && !disp_hides
    |=> access_ans.granted)
    else $error("display selector write refused");
  AST_CONTRAST: assert property (@(posedge core_clk) disable iff (!nrst) // RULE21
    access_req.valid && unit_fitted && !access_req.network && is_contrast
    |=> !access_ans.lock_error)
    else $error("contrast access lock-refused");
  AST_NET_FREE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE12
    access_req.valid && access_req.network && !network_mode |=> !access_ans.lock_error)
    else $error("serial access lock-refused outside network mode");
  AST_LEVEL_LEGAL: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
    lock_level_setting == `NO_LOCK || (lock_level_setting >= 14'h0001 &&
    lock_level_setting <= 14'h0006) || (lock_level_setting >= 14'h0065 &&
    lock_level_setting <= 14'h006A))
    else $error("lock level outside legal set");
  AST_PW_RANGE: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
    registered |-> password_value >= `PW_MIN && password_value <= `PW_MAX)
    else $error("stored password out of range");
  AST_PLAIN_ZERO: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
    reg_rd && reg_addr == `OFS_PASSWORD && registered && !counting |=> reg_rdata == 16'h0000)
    else $error("plain level reported errors");
  AST_DIR_FROZEN: assert property (@(posedge core_clk) disable iff (!nrst) // RULE3
    !extended && !full_clear |=> $stable(direction_lock_setting))
    else $error("direction lock changed while hidden");
  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  COV_LOCK: cover property (@(posedge core_clk) disable iff (!nrst) !locked ##1 locked);
  COV_UNLOCK: cover property (@(posedge core_clk) disable iff (!nrst) locked ##1 !locked);
  COV_LOCKOUT: cover property (@(posedge core_clk) disable iff (!nrst) lockout);
  COV_REFUSE: cover property (@(posedge core_clk) disable iff (!nrst) access_ans.lock_error);
  COV_CLEAR: cover property (@(posedge core_clk) disable iff (!nrst) full_clear && registered);
endmodule : parameter_access_guard

// file: param_guard_regs.svh
`ifndef PARAM_GUARD_REGS_SVH
`define PARAM_GUARD_REGS_SVH
// ----------------------------------------
// Register offsets (word index on the plain port)
// ----------------------------------------
`define OFS_DIR_LOCK 4'h0
`define OFS_DISP_LEVEL 4'h1
`define OFS_LOCK_LEVEL 4'h2
`define OFS_PASSWORD 4'h3
`define OFS_WRITE_PROT 4'h4
`define OFS_SRC_SEL 4'h5
`define OFS_STATUS 4'h6
`define OFS_ACCESS 4'h7
`define OFS_CLEAR 4'h8
// ----------------------------------------
// Values and resets
// ----------------------------------------
`define DIR_BOTH 14'h0000
`define DIR_NO_REV 14'h0001
`define DIR_NO_FWD 14'h0002
`define DISP_SIMPLE 14'h270F
`define DISP_EXTENDED 14'h0000
`define NO_LOCK 14'h270F
`define PW_MIN 14'h03E8
`define PW_MAX 14'h270E
`define PW_IGNORE0 14'h0000
`define LVL_CNT_BASE 14'h0064
`define LOCK_ERR_LIMIT 3'h5
`define SRC_SEL_PANEL_ONLY 14'h0002
`define SRC_SEL_RESET 14'h270F
`define WP_RESET 14'h0000
`define WP_NONE 14'h0001
`define PARAM_CONTRAST 10'h3DF
`define PARAM_JOG_SPEED 10'h00F
`define PARAM_JOG_RAMP 10'h010
`define PARAM_WRITE_PROT 10'h04D
`define PARAM_DISP_LEVEL 10'h0A0
`define PARAM_LOCK_LEVEL 10'h128
`define PARAM_PASSWORD 10'h129
// Status bit positions
`define ST_LOCKED 0
`define ST_REGISTERED 1
`define ST_LOCKOUT 2
`endif

// file: param_guard_pkg.sv
package param_guard_pkg;
  typedef struct packed {
    logic fwd;
    logic rev;
  } dir_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic network;
    logic simple;
    logic [9:0] param;
  } access_req_t;

  typedef struct packed {
    logic done;
    logic granted;
    logic lock_error;
  } access_ans_t;
endpackage : param_guard_pkg

// file: access_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Panel, parameter unit or serial host
// ----------------------------------------
module access_host_model (
  input wire logic core_clk,
  output param_guard_pkg::access_req_t access_req,
  input wire param_guard_pkg::access_ans_t access_ans
);
  initial access_req = '0;

  // One-cycle request; the answer is taken one cycle after it
  task automatic issue(input logic wr, input logic nw, input logic simple,
                       input logic [9:0] p, output param_guard_pkg::access_ans_t ans);
    param_guard_pkg::access_req_t req;
    req = '{valid: 1'b1, write: wr, network: nw, simple: simple, param: p};
    @(posedge core_clk);
    access_req <= req;
    @(posedge core_clk);
    req = ~req;
    req.valid = 1'b0;
    // Released fields flip so that nothing can lean on a stale value
    access_req <= req;
    #1;
    ans = access_ans;
  endtask : issue
endmodule : access_host_model

// file: tb_parameter_access_guard.sv
`timescale 1ns/1ps
`include "param_guard_regs.svh"
module tb_parameter_access_guard;
  localparam logic [13:0] PW_OK = 14'h04D2;
  localparam logic [13:0] PW_BAD = 14'h04D3;
  localparam logic [6:1][3:0] BLOCK = 24'hC3F82A;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  param_guard_pkg::dir_cmd_t panel_dir = 2'h0;
  param_guard_pkg::dir_cmd_t unit_dir = 2'h0;
  param_guard_pkg::dir_cmd_t net_dir = 2'h0;
  param_guard_pkg::dir_cmd_t run_dir;
  logic forward_start_input = 1'b0;
  logic reverse_start_input = 1'b0;
  logic running = 1'b0;
  logic network_mode = 1'b0;
  logic unit_fitted = 1'b0;
  logic local_is_unit = 1'b0;
  logic local_operator_path_unit = 1'b0;
  logic internal_write = 1'b0;
  param_guard_pkg::access_req_t access_req;
  param_guard_pkg::access_ans_t access_ans;
  param_guard_pkg::access_ans_t ans;
  logic lock_error_display;
  logic [15:0] rd;
  int error_cnt = 0;
  int check_count = 0;

  always #5 core_clk = ~core_clk;

  parameter_access_guard dut_u (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .panel_dir(panel_dir),
    .unit_dir(unit_dir), .forward_start_input(forward_start_input),
    .reverse_start_input(reverse_start_input), .net_dir(net_dir), .run_dir(run_dir),
    .running(running), .network_mode(network_mode), .unit_fitted(unit_fitted),
    .local_is_unit(local_is_unit), .local_operator_path_unit(local_operator_path_unit),
    .access_req(access_req), .internal_write(internal_write), .access_ans(access_ans),
    .lock_error_display(lock_error_display)
  );
  access_host_model host_u (.core_clk(core_clk), .access_req(access_req), .access_ans(access_ans));

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [13:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= {2'b00, d};
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic expect_reg(input string what, input logic [3:0] a, input logic [13:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, {2'b00, v}, reg_rdata);
  endtask : expect_reg
  task automatic acc(input string what, input logic wr, input logic nw, input logic simple,
                     input logic [9:0] p, input logic g, input logic le);
    host_u.issue(wr, nw, simple, p, ans);
    chk(what, {13'h0, 1'b1, g, le}, {13'h0, ans.done, ans.granted, ans.lock_error});
  endtask : acc
  // Order: running, network mode, unit fitted, local is unit, from unit, internal
  task automatic set_env(input logic [5:0] v);
    @(posedge core_clk);
    {running, network_mode, unit_fitted, local_is_unit, local_operator_path_unit,
      internal_write} <= v;
  endtask : set_env
  task automatic dir_drive(input int s, input logic [1:0] v);
    @(posedge core_clk);
    panel_dir <= (s == 0) ? v : 2'b00;
    unit_dir <= (s == 1) ? v : 2'b00;
    forward_start_input <= (s == 2) && v[1];
    reverse_start_input <= (s == 2) && v[0];
    net_dir <= (s == 3) ? v : 2'b00;
    @(posedge core_clk);
    #1;
  endtask : dir_drive

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    expect_reg("dir lock", `OFS_DIR_LOCK, `DIR_BOTH);
    expect_reg("display", `OFS_DISP_LEVEL, `DISP_SIMPLE);
    expect_reg("lock level", `OFS_LOCK_LEVEL, `NO_LOCK);
    expect_reg("password", `OFS_PASSWORD, `NO_LOCK);
    expect_reg("unmapped", 4'h7, 14'h0000);
  endtask : t_reset
  task automatic t_direction();
    wr_reg(`OFS_DIR_LOCK, `DIR_NO_REV);
    expect_reg("dir hidden", `OFS_DIR_LOCK, `DIR_BOTH);
    set_env(6'b100000);
    wr_reg(`OFS_DISP_LEVEL, `DISP_EXTENDED);
    expect_reg("display running", `OFS_DISP_LEVEL, `DISP_EXTENDED);
    set_env(6'b000000);
    for (int c = 0; c < 3; c++) begin
      wr_reg(`OFS_DIR_LOCK, c[13:0]);
      for (int s = 0; s < 4; s++) begin
        for (int d = 0; d < 2; d++) begin
          dir_drive(s, (d == 0) ? 2'b10 : 2'b01);
          chk("run dir", {14'h0, d == 0 && c != 2, d == 1 && c != 1}, {14'h0, run_dir});
        end
      end
    end
    dir_drive(4, 2'b00);
  endtask : t_direction
  task automatic t_display();
    wr_reg(`OFS_WRITE_PROT, `WP_NONE);
    acc("write protected", 1'b1, 1'b0, 1'b1, `PARAM_JOG_SPEED, 1'b0, 1'b0);
    wr_reg(`OFS_WRITE_PROT, `WP_RESET);
    wr_reg(`OFS_SRC_SEL, `SRC_SEL_PANEL_ONLY);
    wr_reg(`OFS_DISP_LEVEL, `DISP_SIMPLE);
    set_env(6'b100000);
    acc("run write", 1'b1, 1'b0, 1'b1, `PARAM_JOG_SPEED, 1'b0, 1'b0);
    acc("run display", 1'b1, 1'b0, 1'b1, `PARAM_DISP_LEVEL, 1'b1, 1'b0);
    acc("hidden read", 1'b0, 1'b0, 1'b0, 10'h050, 1'b0, 1'b0);
    set_env(6'b010000);
    acc("panel-only read", 1'b0, 1'b1, 1'b0, 10'h050, 1'b0, 1'b0);
    wr_reg(`OFS_DISP_LEVEL, `DISP_EXTENDED);
    wr_reg(`OFS_SRC_SEL, `SRC_SEL_RESET);
    wr_reg(`OFS_DISP_LEVEL, `DISP_SIMPLE);
    acc("serial read", 1'b0, 1'b1, 1'b0, 10'h050, 1'b1, 1'b0);
    set_env(6'b001110);
    acc("jog via unit", 1'b0, 1'b0, 1'b0, `PARAM_JOG_RAMP, 1'b1, 1'b0);
    set_env(6'b000000);
  endtask : t_display
  task automatic t_password();
    wr_reg(`OFS_DISP_LEVEL, `DISP_EXTENDED);
    wr_reg(`OFS_PASSWORD, PW_OK);
    expect_reg("no level", `OFS_STATUS, 14'h0000);
    wr_reg(`OFS_LOCK_LEVEL, `LVL_CNT_BASE + 14'h0001);
    expect_reg("level", `OFS_LOCK_LEVEL, 14'h0065);
    wr_reg(`OFS_DISP_LEVEL, `DISP_SIMPLE);
    wr_reg(`OFS_PASSWORD, PW_OK);
    expect_reg("locked", `OFS_STATUS, 14'h0003);
    expect_reg("count read", `OFS_PASSWORD, 14'h0000);
    acc("local write", 1'b1, 1'b0, 1'b1, `PARAM_JOG_SPEED, 1'b0, 1'b1);
    chk("lock display", 16'h0001, {15'h0, lock_error_display});
    for (int i = 1; i <= 5; i++) begin
      wr_reg(`OFS_PASSWORD, PW_BAD);
      expect_reg("error count", `OFS_PASSWORD, i[13:0]);
      wr_reg(`OFS_PASSWORD, (i == 1) ? `PW_IGNORE0 : `NO_LOCK);
      expect_reg("ignored", `OFS_PASSWORD, i[13:0]);
    end
    wr_reg(`OFS_PASSWORD, PW_OK);
    expect_reg("lockout", `OFS_STATUS, 14'h0007);
    wr_reg(`OFS_CLEAR, 14'h0001);
    expect_reg("cleared level", `OFS_LOCK_LEVEL, `NO_LOCK);
    expect_reg("cleared pw", `OFS_PASSWORD, `NO_LOCK);
    expect_reg("cleared status", `OFS_STATUS, 14'h0000);
  endtask : t_password
  task automatic t_levels();
    wr_reg(`OFS_DISP_LEVEL, `DISP_EXTENDED);
    set_env(6'b010000);
    for (int l = 1; l <= 6; l++) begin
      wr_reg(`OFS_LOCK_LEVEL, l[13:0]);
      wr_reg(`OFS_PASSWORD, PW_OK);
      for (int k = 0; k < 4; k++) begin
        acc("level gate", k[0], k[1], 1'b1, `PARAM_JOG_SPEED, !BLOCK[l][k], BLOCK[l][k]);
      end
      wr_reg(`OFS_PASSWORD, PW_BAD);
      expect_reg("plain count", `OFS_PASSWORD, 14'h0000);
      wr_reg(`OFS_PASSWORD, PW_OK);
      expect_reg("unlocked", `OFS_STATUS, 14'h0000);
    end
  endtask : t_levels
  task automatic t_exempt();
    wr_reg(`OFS_LOCK_LEVEL, 14'h0004);
    wr_reg(`OFS_PASSWORD, PW_OK);
    set_env(6'b001110);
    acc("contrast", 1'b0, 1'b0, 1'b0, `PARAM_CONTRAST, 1'b1, 1'b0);
    set_env(6'b001100);
    acc("other unit", 1'b0, 1'b0, 1'b1, `PARAM_JOG_SPEED, 1'b1, 1'b0);
    acc("net outside mode", 1'b0, 1'b1, 1'b1, `PARAM_JOG_SPEED, 1'b1, 1'b0);
    set_env(6'b000001);
    acc("internal", 1'b1, 1'b0, 1'b0, 10'h050, 1'b1, 1'b0);
    set_env(6'b100000);
    wr_reg(`OFS_CLEAR, 14'h0001);
    expect_reg("clear while running", `OFS_STATUS, 14'h0003);
    set_env(6'b000000);
    wr_reg(`OFS_CLEAR, 14'h0001);
    expect_reg("clear", `OFS_STATUS, 14'h0000);
  endtask : t_exempt

  // ----------------------------------------
  // Run and verdict
  // ----------------------------------------
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_direction();
    t_display();
    t_password();
    t_levels();
    t_exempt();
    tally_and_finish();
  end
  // Watchdog so a stuck handshake still ends in a verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_parameter_access_guard
